// file: rtl/cpu_branch_return_defines.svh
// Purpose: Constants for the branch and interrupt-return decoder.
// Assumes: Included by its bare name.
// Notes: Working register n lives at data address WREG_BASE + n.
`ifndef CPU_BRANCH_RETURN_DEFINES_SVH
`define CPU_BRANCH_RETURN_DEFINES_SVH
`define OP_LO_DEC_BRANCH 4'hA
`define OP_LO_COND_JUMP 4'hD
`define OP_INT_RETURN 8'hBF
`define OP_INT_DISABLE 8'h8F
`define OP_INT_ENABLE 8'h9F
`define LEN_DEC_BRANCH 16'h0002
`define LEN_COND_JUMP 16'h0003
`define LEN_ONE 16'h0001
`define STACK_POP_TWO 8'h02
`define WREG_BASE 8'hE0
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define IEN_BIT 7
`define PC_RESET 16'h0000
`define SP_RESET 8'hFF
`define FLAGS_RESET 8'h00
`define IRQ_CTL_RESET 8'h00
`endif

// file: rtl/cpu_branch_return_pkg.sv
// Purpose: Types for the branch and interrupt-return decoder.
// Assumes: Nothing beyond the defines header.
// Notes: Types only.
package cpu_branch_return_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_dj_read,
        st_ir_flags,
        st_ir_high,
        st_ir_low
    } state_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } instr_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic sp_ld;
        logic [7:0] sp_val;
    } loader_t;
    typedef struct packed {
        state_t st;
        instr_t ins;
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] flags;
        logic [7:0] irq_ctl;
        logic ready;
        logic done;
        logic illegal;
    } core_t;
endpackage

// file: rtl/data_ram.sv
// Purpose: 256-byte internal data space holding registers and stack.
// Assumes: One port; write and read share the address.
// Notes: Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module data_ram (
    input wire logic mclk,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [0:255];
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule
`default_nettype wire

// file: rtl/cpu_branch_return_decode.sv
// Purpose: Executes decrement-branch, conditional jump, interrupt return and enable toggles.
// Assumes: One instruction is offered at a time with all its bytes; ready gates it.
// Notes: Other opcodes step the program counter by one and pulse illegal.
//        Data space is one single-ported RAM, so every pop costs a cycle of latency.
//        Instructions and loader traffic are refused on the first edge after reset.
//        Only bit 7 of the interrupt control register is kept; the rest stay zero.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_branch_return_defines.svh"
module cpu_branch_return_decode (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire cpu_branch_return_pkg::instr_t instr,
    input wire cpu_branch_return_pkg::loader_t loader,
    output logic ready,
    output logic done,
    output logic illegal,
    output logic [15:0] pc,
    output logic [7:0] sp,
    output logic [7:0] flags,
    output logic [7:0] irq_ctl
);
    cpu_branch_return_pkg::core_t cur_q;
    cpu_branch_return_pkg::core_t cur_d;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata_q;
    logic [7:0] dec_val;
    logic take_instr;

    // Working register n sits at a fixed base in data space.
    function automatic logic [7:0] wreg_addr(input logic [3:0] n);
        wreg_addr = `WREG_BASE | {4'h0, n};
    endfunction

    function automatic logic [15:0] pc_after(input logic [15:0] p, input logic [15:0] len);
        pc_after = p + len;
    endfunction

    // The displacement is signed and counts from the byte after the instruction.
    function automatic logic [15:0] rel_target(input logic [15:0] p, input logic [7:0] d);
        logic [15:0] ext;
        ext = {{8{d[7]}}, d};
        rel_target = pc_after(p, `LEN_DEC_BRANCH) + ext;
    endfunction

    // Codes 8 to F are the inverses of codes 0 to 7.
    function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
        logic c;
        logic z;
        logic s;
        logic v;
        logic r;
        c = f[`FLAG_C];
        z = f[`FLAG_Z];
        s = f[`FLAG_S];
        v = f[`FLAG_V];
        case (cc[2:0])
            3'h0: r = 1'b0;
            3'h1: r = s ^ v;
            3'h2: r = z | (s ^ v);
            3'h3: r = c | z;
            3'h4: r = v;
            3'h5: r = s;
            3'h6: r = z;
            default: r = c;
        endcase
        if (cc[3]) begin
            cond_true = ~r;
        end else begin
            cond_true = r;
        end
    endfunction

    // One shared port keeps the data space small; the cost is one extra cycle per pop.
    data_ram u_ram (
        .mclk(mclk),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(ram_wdata),
        .rdata_q(ram_rdata_q)
    );

    // The decrement leaves the flags alone; only the register and the counter change.
    assign dec_val = ram_rdata_q - 8'h01;
    // Loader traffic wins over an offered instruction, so preloads never race a fetch.
    assign take_instr = cur_q.ready && instr_valid && !loader.wr && !loader.sp_ld;

    // Defaults hold all state, drop the pulses and park the RAM address on the stack.
    always_comb begin
        cur_d = cur_q;
        cur_d.done = 1'b0;
        cur_d.illegal = 1'b0;
        ram_we = 1'b0;
        ram_addr = cur_q.sp;
        ram_wdata = loader.data;
        case (cur_q.st)
            cpu_branch_return_pkg::st_idle: begin
                if (cur_q.ready && loader.wr) begin
                    ram_we = 1'b1;
                    ram_addr = loader.addr;
                end
                if (cur_q.ready && loader.sp_ld) begin
                    cur_d.sp = loader.sp_val;
                end
                if (take_instr) begin
                    cur_d.ins = instr;
                    if (instr.opcode[3:0] == `OP_LO_DEC_BRANCH) begin
                        // The RAM answers a cycle late, so the register read starts here.
                        ram_addr = wreg_addr(instr.opcode[7:4]);
                        cur_d.st = cpu_branch_return_pkg::st_dj_read;
                    end else if (instr.opcode[3:0] == `OP_LO_COND_JUMP) begin
                        cur_d.done = 1'b1;
                        if (cond_true(instr.opcode[7:4], cur_q.flags)) begin
                            cur_d.pc = {instr.op1, instr.op2};
                        end else begin
                            cur_d.pc = pc_after(cur_q.pc, `LEN_COND_JUMP);
                        end
                    end else if (instr.opcode == `OP_INT_RETURN) begin
                        ram_addr = cur_q.sp;
                        cur_d.st = cpu_branch_return_pkg::st_ir_flags;
                    end else if (instr.opcode == `OP_INT_DISABLE) begin
                        cur_d.irq_ctl[`IEN_BIT] = 1'b0;
                        cur_d.pc = pc_after(cur_q.pc, `LEN_ONE);
                        cur_d.done = 1'b1;
                    end else if (instr.opcode == `OP_INT_ENABLE) begin
                        cur_d.irq_ctl[`IEN_BIT] = 1'b1;
                        cur_d.pc = pc_after(cur_q.pc, `LEN_ONE);
                        cur_d.done = 1'b1;
                    end else begin
                        // Unknown bytes still advance, so a stray opcode cannot stall the core.
                        cur_d.pc = pc_after(cur_q.pc, `LEN_ONE);
                        cur_d.illegal = 1'b1;
                        cur_d.done = 1'b1;
                    end
                end
            end
            cpu_branch_return_pkg::st_dj_read: begin
                ram_we = 1'b1;
                ram_addr = wreg_addr(cur_q.ins.opcode[7:4]);
                ram_wdata = dec_val;
                if (dec_val != 8'h00) begin
                    cur_d.pc = rel_target(cur_q.pc, cur_q.ins.op1);
                end else begin
                    cur_d.pc = pc_after(cur_q.pc, `LEN_DEC_BRANCH);
                end
                cur_d.done = 1'b1;
                cur_d.st = cpu_branch_return_pkg::st_idle;
            end
            cpu_branch_return_pkg::st_ir_flags: begin
                // Every flag takes the popped value.
                cur_d.flags = ram_rdata_q;
                cur_d.sp = cur_q.sp + 8'h01;
                ram_addr = cur_q.sp + 8'h01;
                cur_d.st = cpu_branch_return_pkg::st_ir_high;
            end
            cpu_branch_return_pkg::st_ir_high: begin
                // The stack is big-endian: the high byte sits at the lower address.
                // High byte first.
                cur_d.pc[15:8] = ram_rdata_q;
                ram_addr = cur_q.sp + 8'h01;
                cur_d.st = cpu_branch_return_pkg::st_ir_low;
            end
            cpu_branch_return_pkg::st_ir_low: begin
                cur_d.pc[7:0] = ram_rdata_q;
                cur_d.sp = cur_q.sp + `STACK_POP_TWO;
                cur_d.irq_ctl[`IEN_BIT] = 1'b1;
                cur_d.done = 1'b1;
                cur_d.st = cpu_branch_return_pkg::st_idle;
            end
            default: begin
                cur_d.st = cpu_branch_return_pkg::st_idle;
            end
        endcase
        // Ready is registered, so it reflects the state being entered.
        cur_d.ready = (cur_d.st == cpu_branch_return_pkg::st_idle);
    end

    // Ready resets low, so nothing is taken on the first edge after release.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cur_q.st <= cpu_branch_return_pkg::st_idle;
            cur_q.ins <= '0;
            cur_q.pc <= `PC_RESET;
            cur_q.sp <= `SP_RESET;
            cur_q.flags <= `FLAGS_RESET;
            cur_q.irq_ctl <= `IRQ_CTL_RESET;
            cur_q.ready <= 1'b0;
            cur_q.done <= 1'b0;
            cur_q.illegal <= 1'b0;
        end else begin
            cur_q <= cur_d;
        end
    end

    // Every output is a field of the state register.
    assign ready = cur_q.ready;
    assign done = cur_q.done;
    assign illegal = cur_q.illegal;
    assign pc = cur_q.pc;
    assign sp = cur_q.sp;
    assign flags = cur_q.flags;
    assign irq_ctl = cur_q.irq_ctl;
endmodule
`default_nettype wire

// file: testbench/cpu_branch_return_checker.sv
// Purpose: Port assertions for the branch and return decoder.
// Assumes: Bound to the decoder top; sees its ports only.
// Notes: One clock domain, so one default clocking.
`timescale 1ns/1ps
`default_nettype none
module cpu_branch_return_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire cpu_branch_return_pkg::instr_t instr,
    input wire cpu_branch_return_pkg::loader_t loader,
    input wire logic ready,
    input wire logic done,
    input wire logic illegal,
    input wire logic [15:0] pc,
    input wire logic [7:0] sp,
    input wire logic [7:0] flags,
    input wire logic [7:0] irq_ctl
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire logic tk = ready && instr_valid && !loader.wr && !loader.sp_ld;
    wire logic [7:0] op = instr.opcode;
    chk_enable_set: assert property (tk && op == 8'h9F
        |=> done && irq_ctl[7] && $stable(flags)) else $error("enable not set");
    chk_enable_clear: assert property (tk && op == 8'h8F
        |=> done && !irq_ctl[7] && $stable(flags)) else $error("enable not cleared");
    chk_jump_taken: assert property (tk && op == 8'h8D
        |=> pc == {$past(instr.op1), $past(instr.op2)}) else $error("jump missed");
    chk_jump_skip: assert property (tk && op == 8'h0D
        |=> pc == $past(pc) + 16'h0003) else $error("false jump moved pc");
    chk_return_wait: assert property (tk && op == 8'hBF
        |=> !ready [*3] ##1 (ready && done)) else $error("return timing wrong");
    chk_flag_pop: assert property (tk && op == 8'hBF
        |=> ##1 sp == $past(sp, 2) + 8'h01) else $error("flag pop wrong");
    chk_return_end: assert property (tk && op == 8'hBF
        |=> ##3 sp == $past(sp, 4) + 8'h03 && irq_ctl[7]) else $error("return end wrong");
    chk_decrement_branch_nonzero_time: assert property (tk && op[3:0] == 4'hA
        |=> !done ##1 (done && ready)) else $error("decrement timing wrong");
    chk_other_step: assert property (illegal
        |-> done && pc == $past(pc) + 16'h0001) else $error("illegal step wrong");
endmodule
`default_nettype wire

// file: testbench/prog_mem_model.sv
// Purpose: Program memory offering the three bytes at pc.
// Assumes: The bench fills bytes before it offers them.
// Notes: Unfilled bytes hold a changing pattern, not zero.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    input wire logic [15:0] pc,
    output var cpu_branch_return_pkg::instr_t instr
);
    logic [7:0] mem [65536];
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h5A ^ i[7:0];
        end
    end
    assign instr = {mem[pc], mem[pc + 16'h1], mem[pc + 16'h2]};
endmodule
`default_nettype wire

// file: testbench/test_cpu_branch_return_decode.sv
// Purpose: Self-checking bench for the branch and return decoder.
// Assumes: Instruction bytes come from the memory model at pc.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_branch_return_decode;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    cpu_branch_return_pkg::loader_t loader = '0;
    cpu_branch_return_pkg::instr_t instr;
    logic ready, done, illegal;
    logic [15:0] pc, epc;
    logic [7:0] sp, flags, irq_ctl;
    int n_errors = 0;
    int check_count = 0;
    initial begin
        forever #20 mclk = ~mclk;
    end
    prog_mem_model i_pm (.pc(pc), .instr(instr));
    cpu_branch_return_decode i_dut (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr(instr), .loader(loader), .ready(ready), .done(done), .illegal(illegal),
        .pc(pc), .sp(sp), .flags(flags), .irq_ctl(irq_ctl));
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ld(input logic [7:0] a, input logic [7:0] d, input logic s);
        @(negedge mclk);
        loader = '{~s, a, d, s, a};
        @(negedge mclk);
        loader = '0;
    endtask
    task automatic run(input logic [23:0] ins);
        int n;
        n = 0;
        // One edge passes first, so a back-to-back call never re-raises valid in one step.
        @(negedge mclk);
        while (ready !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        if (ready !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t ready timeout", $time);
            finish_test();
        end
        {i_pm.mem[pc], i_pm.mem[pc + 16'h1], i_pm.mem[pc + 16'h2]} = ins;
        instr_valid = 1'b1;
        do begin
            @(negedge mclk);
            instr_valid = 1'b0;
            n++;
        end while (done !== 1'b1 && n < 16);
        if (done !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t done timeout", $time);
            finish_test();
        end
    endtask
    function automatic logic cc_true(input logic [7:0] f, input logic [3:0] cc);
        logic [7:0] t;
        t = {f[7:4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
        return t[cc[2:0]] ^ cc[3];
    endfunction
    task automatic t_enable;
        run(24'h9F0000);
        chk(irq_ctl, 16'h0080);
        run(24'h8F0000);
        chk(irq_ctl, 16'h0000);
        epc = epc + 16'h0002;
        chk(pc, epc);
    endtask
    task automatic t_jump(input logic [7:0] f);
        logic [15:0] tgt;
        for (int cc = 0; cc < 16; cc++) begin
            tgt = {8'h20, cc[3:0], 4'h0};
            run({cc[3:0], 4'hD, tgt});
            epc = cc_true(f, cc[3:0]) ? tgt : epc + 16'h0003;
            chk(pc, epc);
        end
    endtask
    task automatic t_return;
        ld(8'h40, 8'h00, 1'b1);
        ld(8'h40, 8'hA5, 1'b0);
        ld(8'h41, 8'h12, 1'b0);
        ld(8'h42, 8'h34, 1'b0);
        run(24'hBF0000);
        chk(flags, 16'h00A5);
        chk(pc, 16'h1234);
        chk(sp, 16'h0043);
        chk(irq_ctl, 16'h0080);
        epc = 16'h1234;
    endtask
    task automatic t_reset;
        @(negedge mclk);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        chk({sp, flags}, 16'hFF00);
        chk(pc, 16'h0000);
        chk(irq_ctl, 16'h0000);
        chk(ready, 16'h0000);
        @(negedge mclk);
        chk(ready, 16'h0001);
        run(24'h9F0000);
        chk(irq_ctl, 16'h0080);
        chk(pc, 16'h0001);
    endtask
    task automatic t_dec_branch;
        ld(8'hE3, 8'h02, 1'b0);
        run(24'h3AFC00);
        epc = epc - 16'h0002;
        chk(pc, epc);
        run(24'h3AFC00);
        epc = epc + 16'h0002;
        chk(pc, epc);
        run(24'h000000);
        chk(illegal, 16'h0001);
        chk(pc, epc + 16'h0001);
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        chk({sp, flags}, 16'hFF00);
        chk(pc, 16'h0000);
        epc = 16'h0000;
        t_enable();
        t_jump(8'h00);
        t_return();
        t_jump(8'hA5);
        t_dec_branch();
        t_reset();
        finish_test();
    end
endmodule
bind cpu_branch_return_decode cpu_branch_return_checker i_chk (.mclk(mclk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr(instr), .loader(loader), .ready(ready), .done(done),
    .illegal(illegal), .pc(pc), .sp(sp), .flags(flags), .irq_ctl(irq_ctl));
`default_nettype wire
